// ==== shared/sac_pkg.sv ====
// sar converter control: shared constants and types
// assumes both ends compile against this package
package sac_pkg;
    localparam int RES_BITS = 14;
    localparam int CLK_PERIOD_NS = 50;
    localparam int CAL_DELAY_US = 40000;
    localparam int CAL_DELAY_CYC = (CAL_DELAY_US * 1000) / CLK_PERIOD_NS;
    localparam int CONV_TIME_NS = 700;
    localparam int CONV_CYC = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CAL_RUN_CYC = 64;
    localparam int ACC_MAX = 1024;
    localparam int ACC_W = RES_BITS + 10;
    localparam int SCLK_DIV = 4;
    localparam logic [7:0] CMD_RECAL = 8'ha5;
    localparam logic [7:0] CMD_NONE = 8'h00;
    typedef enum logic [2:0] {
        SAC_PWRUP = 3'h0,
        SAC_CAL = 3'h1,
        SAC_STBY = 3'h2,
        SAC_CONV = 3'h3,
        SAC_DONE = 3'h4
    } sac_state_e;
endpackage

// ==== shared/sac_link_if.sv ====
// sar converter control: link between host and device
// assumes the bench joins the two modports
`timescale 1ns/10ps
interface sac_link_if;
    logic conversionStartStrobe;
    logic serialClk;
    logic serialResultOut;
    logic serialCmdIn;
    logic busyOut;
    modport device (
        input conversionStartStrobe,
        input serialClk,
        input serialCmdIn,
        output serialResultOut,
        output busyOut
    );
    modport host (
        output conversionStartStrobe,
        output serialClk,
        output serialCmdIn,
        input serialResultOut,
        input busyOut
    );
endinterface

// ==== rtl/sac_device.sv ====
// sar converter control: device end
// assumes the link pins are asynchronous to core_clk
`timescale 1ns/10ps
module sac_device import sac_pkg::*; #(
    parameter int RES = RES_BITS,
    parameter int CAL_DELAY = CAL_DELAY_CYC,
    parameter int ACC_LEN = ACC_MAX
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // link
    sac_link_if.device link,
    // user side
    input wire logic [RES-1:0] analogSample,
    output logic [RES-1:0] lastResult,
    output logic [ACC_W-1:0] accumSum,
    output logic accumValid,
    output logic calibrating
);
    // ****************
    // pin synchronisers
    // ****************
    logic [1:0] cnvSync_reg, sclkSync_reg, cmdSync_reg;
    logic cnvPrev_reg, sclkPrev_reg;
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            cnvSync_reg <= 2'h0;
            sclkSync_reg <= 2'h0;
            cmdSync_reg <= 2'h0;
            cnvPrev_reg <= 1'b0;
            sclkPrev_reg <= 1'b0;
        end else begin
            cnvSync_reg <= {cnvSync_reg[0], link.conversionStartStrobe};
            sclkSync_reg <= {sclkSync_reg[0], link.serialClk};
            cmdSync_reg <= {cmdSync_reg[0], link.serialCmdIn};
            cnvPrev_reg <= cnvSync_reg[1];
            sclkPrev_reg <= sclkSync_reg[1];
        end
    end
    wire cnvRise = cnvSync_reg[1] & ~cnvPrev_reg;
    wire cnvLow = ~cnvSync_reg[1];
    wire sclkRise = sclkSync_reg[1] & ~sclkPrev_reg;
    wire sclkFall = ~sclkSync_reg[1] & sclkPrev_reg;

    // ****************
    // control state
    // ****************
    sac_state_e state_reg, state_next;
    logic [31:0] cnt_reg, cnt_next;
    logic [RES-1:0] shift_reg;
    logic [7:0] cmd_reg;
    logic recalReq_reg;
    logic [10:0] accCnt_reg;
    logic [ACC_W-1:0] accAcc_reg;
    wire calDelayDone = (cnt_reg >= 32'(CAL_DELAY - 1));
    wire calRunDone = (cnt_reg >= 32'(CAL_RUN_CYC - 1));
    wire convDone = (cnt_reg >= 32'(CONV_CYC - 1));
    wire inStandby = (state_reg == SAC_STBY);
    wire [7:0] cmdShifted = {cmd_reg[6:0], cmdSync_reg[1]};
    wire recalHit = inStandby & sclkRise & (cmdShifted == CMD_RECAL);

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg + 32'h1;
        case (state_reg)
            SAC_PWRUP: if (calDelayDone) begin
                state_next = SAC_CAL;
                cnt_next = 32'h0;
            end
            SAC_CAL: if (calRunDone) begin
                state_next = SAC_STBY;
                cnt_next = 32'h0;
            end
            SAC_STBY: begin
                cnt_next = 32'h0;
                if (cnvRise) begin
                    state_next = SAC_CONV;
                end else if (recalReq_reg) begin
                    state_next = SAC_CAL;
                end
            end
            SAC_CONV: if (convDone) begin
                state_next = SAC_DONE;
                cnt_next = 32'h0;
            end
            SAC_DONE: begin
                cnt_next = 32'h0;
                if (cnvLow) begin
                    state_next = SAC_STBY;
                end
            end
            default: begin
                state_next = SAC_PWRUP;
                cnt_next = 32'h0;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            state_reg <= SAC_PWRUP;
            cnt_reg <= 32'h0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
        end
    end

    // ****************
    // result, readout and command
    // ****************
    // sample captured at conversion end, so readout carries no latency
    wire captureNow = (state_reg == SAC_CONV) & convDone;
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            lastResult <= '0;
            shift_reg <= '0;
            cmd_reg <= CMD_NONE;
            recalReq_reg <= 1'b0;
        end else begin
            if (captureNow) begin
                lastResult <= analogSample;
                shift_reg <= analogSample;
            end else if (inStandby & sclkFall) begin
                shift_reg <= {shift_reg[RES-2:0], 1'b0};
            end
            if (inStandby & sclkRise) begin
                cmd_reg <= recalHit ? CMD_NONE : cmdShifted;
            end
            // set wins over clear
            if (recalHit) begin
                recalReq_reg <= 1'b1;
            end else if (state_reg == SAC_CAL) begin
                recalReq_reg <= 1'b0;
            end
        end
    end
    // msb first; data only driven out of the shift register
    assign link.serialResultOut = shift_reg[RES-1];
    assign link.busyOut = (state_reg == SAC_CONV);
    assign calibrating = (state_reg == SAC_CAL) | (state_reg == SAC_PWRUP);

    // ****************
    // accumulator
    // ****************
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            accCnt_reg <= 11'h0;
            accAcc_reg <= '0;
            accumSum <= '0;
            accumValid <= 1'b0;
        end else begin
            accumValid <= 1'b0;
            if (captureNow) begin
                if (accCnt_reg == 11'(ACC_LEN - 1)) begin
                    accumSum <= accAcc_reg + ACC_W'(analogSample);
                    accumValid <= 1'b1;
                    accAcc_reg <= '0;
                    accCnt_reg <= 11'h0;
                end else begin
                    accAcc_reg <= accAcc_reg + ACC_W'(analogSample);
                    accCnt_reg <= accCnt_reg + 11'h1;
                end
            end
        end
    end
endmodule // sac_device

// ==== rtl/sac_host.sv ====
// sar converter control: host end
// assumes the device answers over the link interface
`timescale 1ns/10ps
module sac_host import sac_pkg::*; #(
    parameter int RES = RES_BITS,
    parameter int CONV_WAIT = CONV_CYC + 4
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // link
    sac_link_if.host link,
    // user side
    input wire logic startReq,
    input wire logic recalReq,
    input wire logic useBusy,
    output logic ready,
    output logic [RES-1:0] result,
    output logic resultValid
);
    typedef enum logic [2:0] {
        SAH_IDLE = 3'h0,
        SAH_HIGH = 3'h1,
        SAH_READ = 3'h2,
        SAH_CMD = 3'h3
    } sac_host_state_e;
    sac_host_state_e st_reg;
    logic [1:0] busySync_reg, sdoSync_reg;
    logic [7:0] cnt_reg;
    logic [4:0] bits_reg;
    logic [7:0] cmd_reg;
    logic sclk_reg;
    // divider keeps sclk far below 100 MHz and slow enough to sample
    wire divTick = (cnt_reg == 8'(SCLK_DIV - 1));
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            busySync_reg <= 2'h0;
            sdoSync_reg <= 2'h0;
        end else begin
            busySync_reg <= {busySync_reg[0], link.busyOut};
            sdoSync_reg <= {sdoSync_reg[0], link.serialResultOut};
        end
    end
    // without busy, wait past the worst conversion time
    // busy needs five cycles to come back through both synchronisers
    wire convOver = useBusy ? (cnt_reg > 8'h4 && !busySync_reg[1])
                            : (cnt_reg >= 8'(CONV_WAIT));
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            st_reg <= SAH_IDLE;
            cnt_reg <= 8'h0;
            bits_reg <= 5'h0;
            cmd_reg <= 8'h0;
            sclk_reg <= 1'b0;
            link.conversionStartStrobe <= 1'b0;
            link.serialCmdIn <= 1'b0;
            result <= '0;
            resultValid <= 1'b0;
        end else begin
            resultValid <= 1'b0;
            case (st_reg)
                SAH_IDLE: begin
                    cnt_reg <= 8'h0;
                    bits_reg <= 5'h0;
                    if (startReq) begin
                        link.conversionStartStrobe <= 1'b1;
                        st_reg <= SAH_HIGH;
                    end else if (recalReq) begin
                        cmd_reg <= CMD_RECAL;
                        link.serialCmdIn <= CMD_RECAL[7];
                        st_reg <= SAH_CMD;
                    end
                end
                SAH_HIGH: begin
                    cnt_reg <= cnt_reg + 8'h1;
                    if (convOver) begin
                        link.conversionStartStrobe <= 1'b0;
                        cnt_reg <= 8'h0;
                        st_reg <= SAH_READ;
                    end
                end
                SAH_READ: begin
                    cnt_reg <= divTick ? 8'h0 : cnt_reg + 8'h1;
                    if (divTick) begin
                        sclk_reg <= ~sclk_reg;
                        // sample late in the high phase: the device shift lags
                        // each fall by three cycles, plus our own synchroniser
                        if (sclk_reg) begin
                            result <= {result[RES-2:0], sdoSync_reg[1]};
                            bits_reg <= bits_reg + 5'h1;
                            if (bits_reg == 5'(RES - 1)) begin
                                resultValid <= 1'b1;
                                st_reg <= SAH_IDLE;
                            end
                        end
                    end
                end
                SAH_CMD: begin
                    cnt_reg <= divTick ? 8'h0 : cnt_reg + 8'h1;
                    if (divTick) begin
                        sclk_reg <= ~sclk_reg;
                        // next bit goes out with the fall, never with the rise
                        if (sclk_reg) begin
                            link.serialCmdIn <= cmd_reg[6];
                            cmd_reg <= {cmd_reg[6:0], 1'b0};
                            bits_reg <= bits_reg + 5'h1;
                            if (bits_reg == 5'h7) begin
                                st_reg <= SAH_IDLE;
                            end
                        end
                    end
                end
                default: st_reg <= SAH_IDLE;
            endcase
        end
    end
    assign link.serialClk = sclk_reg;
    assign ready = (st_reg == SAH_IDLE);
endmodule // sac_host

// ==== testbench/sac_link_properties.sv ====
// sar converter control: properties of the link between the two ends
// assumes the bench ties these inputs to the link interface signals
`timescale 1ns/10ps
module sac_link_properties (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // link
    input wire logic conversionStartStrobe,
    input wire logic serialClk,
    input wire logic serialResultOut,
    input wire logic serialCmdIn,
    input wire logic busyOut
);
    // ****************************************
    // link properties
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    AST_BUSY_CAUSE:
        assert property ($rose(busyOut) |-> conversionStartStrobe)
        else $error("busy rose without start strobe");
    AST_BUSY_LENGTH:
        assert property ($rose(busyOut) |-> busyOut[*8] ##[1:8] !busyOut)
        else $error("busy length outside conversion time");
    AST_NO_SCLK_IN_CONV:
        assert property (busyOut |-> $stable(serialClk))
        else $error("serial clock moved during conversion");
    AST_STROBE_AFTER_DONE:
        assert property ($fell(conversionStartStrobe) |-> !busyOut)
        else $error("strobe lowered before conversion end");
    AST_STROBE_HOLD:
        assert property ($rose(conversionStartStrobe) |-> conversionStartStrobe[*8])
        else $error("strobe released too early");
    AST_SCLK_HIGH:
        assert property ($rose(serialClk) |-> serialClk[*4] ##1 !serialClk)
        else $error("serial clock high phase wrong");
    // late check only: the device sees clock edges through a synchroniser
    AST_SDO_STEADY:
        assert property ($rose(serialClk) |-> ##2 $stable(serialResultOut)[*2])
        else $error("result bit moved while clock high");
    AST_CMD_SETUP:
        assert property ($changed(serialCmdIn) |-> !serialClk)
        else $error("command bit moved while clock high");
endmodule // sac_link_properties

// ==== testbench/sar_adc_conversion_serial_control_tb_top.sv ====
// sar converter control: self-checking bench, both ends joined
// assumes short calibration delay and accumulator length for run time
`timescale 1ns/10ps
module sar_adc_conversion_serial_control_tb_top import sac_pkg::*; ();
    localparam int CAL_SIM = 50;
    localparam int ACC_SIM = 4;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic startReq = 1'b0;
    logic recalReq = 1'b0;
    logic useBusy = 1'b0;
    logic [RES_BITS-1:0] analogSample = 14'h0000;
    logic ready, resultValid, accumValid, calibrating;
    logic accSeen = 1'b0;
    logic [RES_BITS-1:0] result, lastResult;
    logic [ACC_W-1:0] accumSum, accSum, accExp;
    logic [31:0] rngState = 32'h00000060;
    int err_total = 0;
    int n_checks = 0;

    sac_link_if link ();
    sac_device #(.CAL_DELAY(CAL_SIM), .ACC_LEN(ACC_SIM)) sac_device_i (.core_clk(core_clk),
        .reset_n(reset_n), .link(link), .analogSample(analogSample), .lastResult(lastResult),
        .accumSum(accumSum), .accumValid(accumValid), .calibrating(calibrating));
    sac_host sac_host_i (.core_clk(core_clk), .reset_n(reset_n), .link(link),
        .startReq(startReq), .recalReq(recalReq), .useBusy(useBusy), .ready(ready),
        .result(result), .resultValid(resultValid));
    sac_link_properties sac_link_properties_i (.core_clk(core_clk), .reset_n(reset_n),
        .conversionStartStrobe(link.conversionStartStrobe), .serialClk(link.serialClk),
        .serialResultOut(link.serialResultOut), .serialCmdIn(link.serialCmdIn),
        .busyOut(link.busyOut));

    // ****************************************
    // helpers
    // ****************************************
    initial begin
        forever #25 core_clk = ~core_clk;
    end
    // the sum pulse is one cycle long, so hold it for a later compare
    always @(posedge core_clk) begin
        if (accumValid === 1'b1) begin
            accSeen <= 1'b1;
            accSum <= accumSum;
        end
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    function automatic logic [ACC_W-1:0] accAdd(input logic [ACC_W-1:0] a,
        input logic [RES_BITS-1:0] s);
        return a + ACC_W'(s);
    endfunction
    task automatic tick();
        @(posedge core_clk);
        #5;
    endtask
    task automatic check(input string what, input logic [ACC_W-1:0] exp,
        input logic [ACC_W-1:0] got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic waitReady();
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 300) begin
            tick();
            n++;
        end
    endtask
    task automatic convert(input logic [RES_BITS-1:0] s, input logic busyMode);
        int n;
        analogSample = s;
        useBusy = busyMode;
        waitReady();
        startReq = 1'b1;
        tick();
        startReq = 1'b0;
        n = 0;
        while (resultValid !== 1'b1 && n < 400) begin
            tick();
            n++;
        end
        check("result valid", 1, resultValid);
        check("result", s, result);
        check("last result", s, lastResult);
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        int i;
        int n;
        logic [RES_BITS-1:0] s;
        repeat (6) @(posedge core_clk);
        #5 reset_n = 1'b1;
        check("calibrating after reset", 1, calibrating);
        n = 0;
        while (calibrating !== 1'b0 && n < 2000) begin
            tick();
            n++;
        end
        check("power-up wait length", ACC_W'(CAL_SIM + CAL_RUN_CYC), ACC_W'(n));
        check("standby after calibration", 0, calibrating);
        accExp = '0;
        for (i = 0; i < 16; i++) begin
            rngState = xs(rngState);
            s = (i == 0) ? 14'h0000 : (i == 1) ? 14'h3fff : rngState[RES_BITS-1:0];
            convert(s, i[0]);
            accExp = accAdd(accExp, s);
            if (i % ACC_SIM == ACC_SIM - 1) begin
                check("sum pulse", 1, accSeen);
                check("sum", accExp, accSum);
                accExp = '0;
                accSeen = 1'b0;
            end
        end
        waitReady();
        recalReq = 1'b1;
        tick();
        recalReq = 1'b0;
        n = 0;
        while (calibrating !== 1'b1 && n < 500) begin
            tick();
            n++;
        end
        check("recalibration start", 1, calibrating);
        n = 0;
        while (calibrating !== 1'b0 && n < 500) begin
            tick();
            n++;
        end
        check("standby after recalibration", 0, calibrating);
        convert(14'h2aaa, 1'b1);
        end_of_test();
    end
    // full run is about 2500 cycles
    initial begin
        repeat (20000) @(posedge core_clk);
        err_total++;
        $display("MISMATCH watchdog expected done seen hang");
        end_of_test();
    end
endmodule // sar_adc_conversion_serial_control_tb_top
